/* rtl/nvcr_top.v */
// Purpose: Clock-ratio setup and working options/protection registers of an
//          on-chip nonvolatile memory, with backdoor key unlock.
// Assumes: Register port is 8-bit, read data one cycle after the read strobe.
//          Stored option, protect and key bytes are stable inputs.
// Notes:   Command sequencer and array are outside; this block gates them.
// Overview of operation
// R1 - Top bit of clock setup is read-only loaded flag, set by first write.
// R2 - Low seven bits readable always, writable once after reset.
// R3 - Erase and program disabled until loaded flag is set.
// R4 - Software writes clock setup before any erase or program.
// R5 - Prescaler feeds bus clock, or bus clock divided by eight when bit 6 set.
// R6 - Prescaler output divided by ratio field plus one gives memory clock.
// R7 - Software keeps memory clock between 150 kHz and 200 kHz.
// R8 - One memory clock period is the program/erase timing pulse.
// R9 - Sequencer times each operation as whole number of timing pulses.
// R10 - Recommended: prescale set ratio 12 at 20 MHz, clear ratio 49 at 10 MHz.
// R11 - Module exposes five readable 8-bit control and status registers.
// R12 - Reset copies stored options and protect bytes into working registers.
// R13 - Working options register ignores software writes; reloads only at reset.
// R14 - Unlock-allow bit zero means backdoor key never disengages security.
// R15 - Key comparison writes accepted only from secured firmware, never debug.
// R16 - Matching 8-byte key written in ascending order unsecures until reset.
// R17 - Redirect-off bit set disables vector redirection; clear enables it.
// R18 - Security code 1:0 is unsecured; all other codes mean secure.
// R19 - While secure, block memory access from unsecured sources.
// R20 - Force security code to 1:0 after key match or blank check pass.
// R21 - Blocked secure access: writes ignored, reads return zeros.
// R22 - Key-entry mode set makes key location writes comparison values.
// R23 - Later clock setup writes ignored silently, nothing changes.
`timescale 1ns/1ps
`include "nvcr_defines.vh"

module nvcr_top #(
    parameter RATIO_W = 6
) (
    // Clock and reset
    input  wire        ref_clk_in,
    input  wire        rst_n_in,
    // Register port
    input  wire [3:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    input  wire        reg_src_secure_in,
    output reg  [7:0]  reg_rdata_out,
    // Stored nonvolatile bytes
    input  wire [7:0]  stored_options_byte_in,
    input  wire [7:0]  stored_protect_byte_in,
    input  wire [63:0] stored_unlock_key_in,
    // Debug port and sequencer
    input  wire        debug_protect_wr_in,
    input  wire        blank_check_pass_in,
    // Memory access gate
    input  wire        mem_req_in,
    input  wire        mem_src_secure_in,
    input  wire        mem_wr_in,
    input  wire [7:0]  mem_rdata_in,
    output wire        mem_wr_allow_out,
    output reg  [7:0]  mem_rdata_out,
    // Control outputs
    output wire        erase_prog_enable_out,
    output reg         nvm_pulse_tick_out,
    output wire        redirect_enable_out,
    output wire        secure_out
);

    localparam ST_IDLE  = 3'b001;
    localparam ST_ENTRY = 3'b010;
    localparam ST_FAIL  = 3'b100;

    reg               ratio_loaded_flag_reg;
    reg               prescale_eight_sel_reg;
    reg [RATIO_W-1:0] ratio_reg;
    reg [7:0]         working_options_reg;
    reg [7:0]         working_protect_reg;
    reg               load_pending_reg;
    reg               key_entry_mode_reg;
    reg [2:0]         key_state_reg;
    reg [2:0]         key_state_next;
    reg [3:0]         key_count_reg;
    reg               key_match_reg;
    reg [2:0]         pre_count_reg;
    reg [RATIO_W-1:0] div_count_reg;

    wire wr_setup  = reg_wr_in && (reg_addr_in == `NVCR_OFF_CLK_SETUP);
    wire wr_config = reg_wr_in && (reg_addr_in == `NVCR_OFF_CONFIG);
    wire wr_prot   = reg_wr_in && (reg_addr_in == `NVCR_OFF_PROTECT);
    wire key_addr  = (reg_addr_in >= `NVCR_OFF_KEY_FIRST);
    wire key_wr    = reg_wr_in && key_addr && key_entry_mode_reg
                     && reg_src_secure_in;                                         // R15 R22
    wire [2:0] key_index = reg_addr_in[2:0];

    function [7:0] key_byte;
        input [63:0] key;
        input [2:0]  idx;
        begin
            key_byte = key[8*idx +: 8];
        end
    endfunction

    // Clock setup: write once, flag set on first write
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ratio_loaded_flag_reg  <= 1'b0;                                        // R1
            prescale_eight_sel_reg <= 1'b0;
            ratio_reg              <= {RATIO_W{1'b0}};
        end else if (wr_setup && !ratio_loaded_flag_reg) begin                    // R2 R23
            ratio_loaded_flag_reg  <= 1'b1;                                        // R1
            prescale_eight_sel_reg <= reg_wdata_in[`NVCR_PRESCALE_BIT];
            ratio_reg              <= reg_wdata_in[RATIO_W-1:0];
        end
    end

    assign erase_prog_enable_out = ratio_loaded_flag_reg;                          // R3

    // Prescaler and divider; one tick per memory clock period
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pre_count_reg      <= 3'h0;
            div_count_reg      <= {RATIO_W{1'b0}};
            nvm_pulse_tick_out <= 1'b0;
        end else begin
            nvm_pulse_tick_out <= 1'b0;
            if (ratio_loaded_flag_reg) begin
                if (!prescale_eight_sel_reg || pre_count_reg == 3'h7) begin        // R5
                    pre_count_reg <= 3'h0;
                    if (div_count_reg == ratio_reg) begin                          // R6
                        div_count_reg      <= {RATIO_W{1'b0}};
                        nvm_pulse_tick_out <= 1'b1;                                // R8 R9
                    end else begin
                        div_count_reg <= div_count_reg + 1'b1;
                    end
                end else begin
                    pre_count_reg <= pre_count_reg + 3'h1;
                end
            end
        end
    end

    // Working options and protection, loaded after reset release
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            load_pending_reg    <= 1'b1;
            working_options_reg <= 8'h00;
            working_protect_reg <= 8'h00;
        end else begin
            if (load_pending_reg) begin
                load_pending_reg    <= 1'b0;
                working_options_reg <= stored_options_byte_in & `NVCR_OPTIONS_MASK; // R12 R13
                working_protect_reg <= stored_protect_byte_in;                     // R12
            end else begin
                if (key_match_reg || blank_check_pass_in)
                    working_options_reg[`NVCR_SEC_MSB:0] <= `NVCR_SEC_UNSECURED;   // R20 R16
                if (wr_prot && debug_protect_wr_in)
                    working_protect_reg <= reg_wdata_in;
            end
        end
    end

    // Key entry mode bit
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            key_entry_mode_reg <= 1'b0;
        else if (wr_config && reg_src_secure_in)
            key_entry_mode_reg <= reg_wdata_in[`NVCR_KEYMODE_BIT];                 // R22
    end

    // Key comparison sequencer
    always @* begin
        key_state_next = key_state_reg;
        case (key_state_reg)
            ST_IDLE:  if (key_entry_mode_reg) key_state_next = ST_ENTRY;
            ST_ENTRY: begin
                if (!key_entry_mode_reg)
                    key_state_next = ST_IDLE;
                else if (key_wr && (key_index != key_count_reg[2:0] ||
                         reg_wdata_in != key_byte(stored_unlock_key_in, key_index)))
                    key_state_next = ST_FAIL;                                      // R16
            end
            ST_FAIL:  if (!key_entry_mode_reg) key_state_next = ST_IDLE;
            default:  key_state_next = ST_IDLE;
        endcase
    end

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            key_state_reg <= ST_IDLE;
            key_count_reg <= 4'h0;
            key_match_reg <= 1'b0;
        end else begin
            key_state_reg <= key_state_next;
            key_match_reg <= 1'b0;
            if (key_state_reg == ST_IDLE)
                key_count_reg <= 4'h0;
            else if (key_wr && key_count_reg != 4'h8)
                key_count_reg <= key_count_reg + 4'h1;
            if (key_state_reg == ST_ENTRY && !key_entry_mode_reg &&
                key_count_reg == 4'h8 && working_options_reg[`NVCR_UNLOCK_BIT])
                key_match_reg <= 1'b1;                                             // R14 R16
        end
    end

    assign secure_out = (working_options_reg[`NVCR_SEC_MSB:0] != `NVCR_SEC_UNSECURED); // R18
    assign redirect_enable_out = !working_options_reg[`NVCR_NORED_BIT];            // R17

    // Secure memory gate
    wire mem_ok = !secure_out || mem_src_secure_in;                                 // R19
    assign mem_wr_allow_out = mem_req_in && mem_wr_in && mem_ok;                    // R21

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            mem_rdata_out <= 8'h00;
        else if (mem_req_in && !mem_wr_in)
            mem_rdata_out <= mem_ok ? mem_rdata_in : 8'h00;                        // R21
    end

    // Register read port
    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
            reg_rdata_out <= 8'h00;
        else if (reg_rd_in) begin
            case (reg_addr_in)                                                     // R11
                `NVCR_OFF_CLK_SETUP: reg_rdata_out <= {ratio_loaded_flag_reg, prescale_eight_sel_reg,
                                                       ratio_reg};                 // R2
                `NVCR_OFF_CONFIG:    reg_rdata_out <= {2'h0, key_entry_mode_reg, 5'h00};
                `NVCR_OFF_OPTIONS:   reg_rdata_out <= working_options_reg;
                `NVCR_OFF_PROTECT:   reg_rdata_out <= working_protect_reg;
                `NVCR_OFF_STATUS:    reg_rdata_out <= {4'h0, nvm_pulse_tick_out, redirect_enable_out,
                                                       secure_out, erase_prog_enable_out};
                default:             reg_rdata_out <= 8'h00;
            endcase
        end
    end

endmodule // nvcr_top

/* rtl/nvcr_defines.vh */
// Purpose: Constants for the memory clock setup and options register block
// Assumes: 8-bit register port, byte-wide registers
// Notes:   Offsets are register indices on the local register port
`ifndef NVCR_DEFINES_VH
`define NVCR_DEFINES_VH

// Register offsets
`define NVCR_OFF_CLK_SETUP    4'h0
`define NVCR_OFF_CONFIG       4'h1
`define NVCR_OFF_OPTIONS      4'h2
`define NVCR_OFF_PROTECT      4'h3
`define NVCR_OFF_STATUS       4'h4
`define NVCR_OFF_KEY_FIRST    4'h8
`define NVCR_OFF_KEY_LAST     4'hf

// Clock setup fields
`define NVCR_LOADED_BIT       7
`define NVCR_PRESCALE_BIT     6
`define NVCR_RATIO_MSB        5
`define NVCR_CLK_SETUP_RST    8'h00
`define NVCR_PRESCALE_DIV     4'h8

// Config fields
`define NVCR_KEYMODE_BIT      5
`define NVCR_CONFIG_MASK      8'h20

// Options fields
`define NVCR_UNLOCK_BIT       7
`define NVCR_NORED_BIT        6
`define NVCR_SEC_MSB          1
`define NVCR_SEC_UNSECURED    2'h2
`define NVCR_OPTIONS_MASK     8'hc3

// Status fields
`define NVCR_ST_ENABLE_BIT    0
`define NVCR_ST_SECURE_BIT    1
`define NVCR_ST_REDIR_BIT     2
`define NVCR_ST_TICK_BIT      3

// Timing pulse limits and reference clock period, in ns
`define NVCR_PULSE_MIN_NS     5000
`define NVCR_PULSE_MAX_NS     6700
`define NVCR_CLK_PERIOD_NS    10

`endif

/* bench/nvcr_properties.sv */
// Purpose: Port-level checks of clock setup, options and memory gate
// Assumes: Stored option byte is stable outside reset
// Notes:   Bound to nvcr_top
`timescale 1ns/1ps
module nvcr_properties #(
    parameter RATIO_W = 6
) (
    // Clock and reset
    input wire       ref_clk_in,
    input wire       rst_n_in,
    // Register port
    input wire [3:0] reg_addr_in,
    input wire       reg_wr_in,
    input wire       reg_rd_in,
    input wire [7:0] reg_rdata_out,
    // Stored byte and sequencer
    input wire [7:0] stored_options_byte_in,
    input wire       blank_check_pass_in,
    // Memory gate
    input wire       mem_req_in,
    input wire       mem_src_secure_in,
    input wire       mem_wr_in,
    input wire [7:0] mem_rdata_in,
    input wire       mem_wr_allow_out,
    input wire [7:0] mem_rdata_out,
    // Control outputs
    input wire       erase_prog_enable_out,
    input wire       nvm_pulse_tick_out,
    input wire       redirect_enable_out,
    input wire       secure_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire nonsec_rd = mem_req_in && !mem_wr_in && !mem_src_secure_in;
    AST_LOADED_SET: assert property ($rose(erase_prog_enable_out) |-> $past(reg_wr_in && reg_addr_in == 4'h0))
        else $error("loaded flag rose without setup write");
    AST_LOADED_KEEP: assert property (erase_prog_enable_out |=> erase_prog_enable_out)
        else $error("loaded flag dropped");
    AST_FLAG_READ: assert property (reg_rd_in && reg_addr_in == 4'h0 |=> reg_rdata_out[7] == $past(erase_prog_enable_out))
        else $error("flag readback wrong");
    AST_NO_TICK: assert property (!erase_prog_enable_out |-> !nvm_pulse_tick_out)
        else $error("tick before setup");
    AST_REDIR: assert property (rst_n_in && $past(rst_n_in) |-> redirect_enable_out == !stored_options_byte_in[6])
        else $error("redirect enable wrong");
    AST_SEC_LOAD: assert property ($past(rst_n_in) && stored_options_byte_in[1:0] == 2'h2 |-> !secure_out)
        else $error("unsecured code reads secure");
    AST_SEC_FALL: assert property ($fell(secure_out) && !stored_options_byte_in[7] && stored_options_byte_in[1:0] != 2'h2
        |-> $past(blank_check_pass_in, 1) || $past(blank_check_pass_in, 2) || $past(blank_check_pass_in, 3))
        else $error("security dropped without blank check");
    AST_WR_BLOCK: assert property (secure_out && mem_req_in && mem_wr_in && !mem_src_secure_in |-> !mem_wr_allow_out)
        else $error("unsecured write allowed");
    AST_RD_ZERO: assert property (secure_out && nonsec_rd |=> mem_rdata_out == 8'h00)
        else $error("blocked read not zero");
    AST_RD_PASS: assert property (mem_req_in && !mem_wr_in && mem_src_secure_in |=> mem_rdata_out == $past(mem_rdata_in))
        else $error("secure read data wrong");
    COV_TICK: cover property (nvm_pulse_tick_out);
    COV_UNSEC: cover property ($fell(secure_out));
    COV_LOAD: cover property ($rose(erase_prog_enable_out));
endmodule // nvcr_properties
bind nvcr_top nvcr_properties #(.RATIO_W(RATIO_W)) nvcr_properties_inst (.ref_clk_in, .rst_n_in, .reg_addr_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .stored_options_byte_in, .blank_check_pass_in, .mem_req_in,
    .mem_src_secure_in, .mem_wr_in, .mem_rdata_in, .mem_wr_allow_out, .mem_rdata_out, .erase_prog_enable_out,
    .nvm_pulse_tick_out, .redirect_enable_out, .secure_out);

/* bench/nvcr_top_test.sv */
// Purpose: Directed bench for clock setup, options and security gate
// Assumes: One read per strobe, data sampled the cycle after
// Notes:   Each scenario resets the block first
`timescale 1ns/1ps
module nvcr_top_test;
    reg         clk, rst_n, wr, rd, src, blank, mreq, msrc, mwr;
    reg  [3:0]  addr;
    reg  [7:0]  wdata, opts, mdin, r;
    reg  [63:0] key;
    wire [7:0]  rdata, mdout;
    wire        wr_ok, ep_en, tick, redir, sec;
    integer     n_errors, comparisons, i, j, n;
    nvcr_top nvcr_top_inst (.ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_src_secure_in(src), .reg_rdata_out(rdata),
        .stored_options_byte_in(opts), .stored_protect_byte_in(8'hff), .stored_unlock_key_in(key),
        .debug_protect_wr_in(1'b0), .blank_check_pass_in(blank), .mem_req_in(mreq), .mem_src_secure_in(msrc),
        .mem_wr_in(mwr), .mem_rdata_in(mdin), .mem_wr_allow_out(wr_ok), .mem_rdata_out(mdout),
        .erase_prog_enable_out(ep_en), .nvm_pulse_tick_out(tick), .redirect_enable_out(redir), .secure_out(sec));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task summarize;
        begin
            $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
            if (n_errors == 0 && comparisons > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task do_reset(input [7:0] o);
        begin
            @(posedge clk);
            opts <= o;
            rst_n <= 1'b0;
            repeat (16) @(posedge clk);
            #1 chk({sec, redir, ep_en, tick}, 8'h0c);
            rst_n <= 1'b1;
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
    task wr_reg(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [3:0] a);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 r = rdata;
        end
    endtask
    task wait_tick;
        begin
            n = 0;
            do begin
                @(posedge clk);
                #1 n = n + 1;
            end while (tick !== 1'b1 && n < 600);
            if (tick !== 1'b1) begin
                n_errors = n_errors + 1;
                summarize;
            end
        end
    endtask
    task t_setup(input [7:0] v, input integer per);
        begin
            do_reset(8'h02);
            wr_reg(4'h0, v);
            wr_reg(4'h0, ~v);
            rd_reg(4'h0);
            chk(r, v | 8'h80);
            chk({7'h0, ep_en}, 8'h01);
            wait_tick;
            wait_tick;
            chk(n, per);
            rd_reg(4'h4);
            chk(r, 8'h05);
        end
    endtask
    task t_opts;
        for (i = 0; i < 4; i = i + 1) begin
            do_reset({1'b0, i[0], 4'hf, i[1:0]});
            chk({7'h0, sec}, {7'h0, i != 2});
            chk({7'h0, redir}, {7'h0, !i[0]});
            rd_reg(4'h2);
            chk(r, opts & 8'hc3);
            wr_reg(4'h2, ~opts);
            rd_reg(4'h2);
            chk(r, opts & 8'hc3);
            rd_reg(4'h5);
            chk(r, 8'h00);
        end
    endtask
    task t_unlock(input [7:0] o, input s, input [63:0] k, input e);
        begin
            do_reset(o);
            src <= 1'b0;
            wr_reg(4'h1, 8'h20);
            rd_reg(4'h1);
            chk(r, 8'h00);
            src <= 1'b1;
            wr_reg(4'h1, 8'h20);
            rd_reg(4'h1);
            chk(r, 8'h20);
            src <= s;
            for (j = 0; j < 8; j = j + 1)
                wr_reg(4'h8 + j[3:0], k[8*j +: 8]);
            src <= 1'b1;
            wr_reg(4'h1, 8'h00);
            repeat (2) @(posedge clk);
            #1 chk({7'h0, sec}, {7'h0, e});
        end
    endtask
    task mem_op(input w, input s, input [7:0] e);
        begin
            @(posedge clk);
            mreq <= 1'b1;
            mwr <= w;
            msrc <= s;
            @(posedge clk);
            #1 chk(w ? {7'h0, wr_ok} : mdout, e);
        end
    endtask
    task t_mem;
        begin
            do_reset(8'h03);
            rd_reg(4'h3);
            chk(r, 8'hff);
            mem_op(1'b1, 1'b0, 8'h00);
            mem_op(1'b0, 1'b0, 8'h00);
            mem_op(1'b0, 1'b1, 8'h5a);
            mem_op(1'b1, 1'b1, 8'h01);
            @(posedge clk);
            blank <= 1'b1;
            @(posedge clk);
            blank <= 1'b0;
            repeat (2) @(posedge clk);
            #1 chk({7'h0, sec}, 8'h00);
            mem_op(1'b0, 1'b0, 8'h5a);
            mem_op(1'b1, 1'b0, 8'h01);
        end
    endtask
    initial begin
        {rst_n, wr, rd, src, blank, mreq, msrc, mwr, addr, wdata} = 0;
        opts = 8'h03;
        mdin = 8'h5a;
        key = 64'h0123456789abcdef;
        n_errors = 0;
        comparisons = 0;
        t_setup(8'h03, 4);
        t_setup(8'h41, 16);
        t_setup(8'h4c, 104);
        t_setup(8'h31, 50);
        t_setup(8'h7f, 512);
        t_opts;
        t_unlock(8'h83, 1'b1, key, 1'b0);
        t_unlock(8'h03, 1'b1, key, 1'b1);
        t_unlock(8'h83, 1'b0, key, 1'b1);
        t_unlock(8'h83, 1'b1, ~key, 1'b1);
        t_mem;
        summarize;
    end
endmodule // nvcr_top_test
